// ---- pdma_pkg.sv ----
package pdma_pkg;

    // Register byte offsets
    localparam logic [11:0] PDMA_RX_BUFFER_POINTER    = 12'h000;
    localparam logic [11:0] PDMA_RX_BUFFER_COUNT      = 12'h004;
    localparam logic [11:0] PDMA_TX_BUFFER_POINTER    = 12'h008;
    localparam logic [11:0] PDMA_TX_BUFFER_COUNT      = 12'h00C;
    localparam logic [11:0] PDMA_RX_FOLLOWING_POINTER = 12'h010;
    localparam logic [11:0] PDMA_RX_FOLLOWING_COUNT   = 12'h014;
    localparam logic [11:0] PDMA_TX_FOLLOWING_POINTER = 12'h018;
    localparam logic [11:0] PDMA_TX_FOLLOWING_COUNT   = 12'h01C;
    localparam logic [11:0] PDMA_TRANSFER_CONTROL     = 12'h020;
    localparam logic [11:0] PDMA_TRANSFER_STATE       = 12'h024;

    // Field positions in control and state words
    localparam int PDMA_RX_REQUEST_ENABLE_BIT  = 0;
    localparam int PDMA_RX_REQUEST_DISABLE_BIT = 1;
    localparam int PDMA_TX_REQUEST_ENABLE_BIT  = 8;
    localparam int PDMA_TX_REQUEST_DISABLE_BIT = 9;

    // Counter field width and reset values
    localparam int          PDMA_LEN_W     = 16;
    localparam logic [31:0] PDMA_PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] PDMA_LEN_RESET = 16'h0000;

    // Element size codes and the pointer step they give
    localparam logic [1:0]  PDMA_SIZE_BYTE = 2'h0;
    localparam logic [1:0]  PDMA_SIZE_HALF = 2'h1;
    localparam logic [31:0] PDMA_STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] PDMA_STEP_HALF = 32'h0000_0002;
    localparam logic [31:0] PDMA_STEP_WORD = 32'h0000_0004;

    // Channel index: 0 receive, 1 transmit
    localparam int PDMA_RX = 0;
    localparam int PDMA_TX = 1;

    // End-of-buffer flags handed to the host peripheral
    typedef struct packed {
        logic rx_end_flag;
        logic rx_all_done_flag;
        logic tx_end_flag;
        logic tx_all_done_flag;
    } pdma_flags_s;

    // Whole state of the channel pair
    typedef struct packed {
        logic [1:0][31:0] cur_ptr;
        logic [1:0][15:0] cur_len;
        logic [1:0][31:0] nxt_ptr;
        logic [1:0][15:0] nxt_len;
        logic [1:0]       req_en;
        logic [1:0]       end_flag;
        logic [1:0]       all_done;
        logic [31:0]      prdata;
    } pdma_state_s;

endpackage

// ---- pdma_channel_regs.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
// What this block does
// - Ten registers at offsets 0x00 to 0x24, all reset to zero.
// - Receive count bits 15:0; zero halts, nonzero runs when enabled.
// - Transmit count bits 15:0; zero halts, nonzero runs when enabled.
// - Hold 32-bit following receive pointer and 16-bit following count.
// - Hold 32-bit following transmit pointer and 16-bit following count.
// - Half duplex: receive and transmit views share one storage.
// - Control bit 0 enables receive unless bit 1 also set; zeros ignored.
// - Control bit 1 disables receive requests.
// - Control bit 8 enables transmit requests.
// - Control bit 9 disables transmit requests.
// - Half duplex: receive enable also disables transmit.
// - Half duplex: transmit enable works only without receive enable.
// - Half duplex: receive disable also disables transmit.
// - Half duplex: transmit disable also disables receive.
// - State register shows receive enable bit 0, transmit enable bit 8.
// - Count hitting zero: stop if next zero, else reload and clear next.
// - Pointer advances 1, 2 or 4 bytes per element.
// - End flag when count hits zero; all-done flag when both counts zero.
//
// Notes for users of this block
// - APB answers with no wait state; pready is tied high.
// - Read data is captured in the setup cycle, so a read
//   sees the registers as they stood at the end of setup.
// - Unmapped offsets raise pslverr; such writes are dropped.
// - Control reads as zero; the state register drops writes.
// - A software write to a count or pointer wins over an
//   element completion on that register in the same cycle.
// - A completion that sets an end flag wins over a clear
//   written in the same cycle, so no buffer end is lost.
// - Enable and disable written together: disable wins.
// - On half duplex both views share one storage slot, and
//   a completion from either view counts when that view
//   is enabled.
// - The pointer step follows elem_size at each completion;
//   changing it mid-buffer is left to the user.
module pdma_channel_regs
    import pdma_pkg::*;
#(
    parameter bit HALF_DUPLEX = 1'b0
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Peripheral side
    input  wire logic [1:0]  elem_size,
    input  wire logic        rx_ready,
    input  wire logic        tx_ready,
    input  wire logic        rx_xfer_done,
    input  wire logic        tx_xfer_done,
    output logic             rx_xfer_req,
    output logic             tx_xfer_req,
    output logic [31:0]      rx_mem_addr,
    output logic [31:0]      tx_mem_addr,
    output pdma_flags_s      flags
);

    // All state sits in one packed struct: st_d is built by
    // one always_comb and st_q is its registered copy.
    // Read data rides in the same struct so that prdata
    // comes straight from a flop.
    pdma_state_s st_q;
    pdma_state_s st_d;

    // Pointer step for one element
    // Sizes 2 and 3 both give a word step; no size code is
    // illegal, so a stray code never stalls a channel.
    function automatic logic [31:0] elem_step(input logic [1:0] size);
        logic [31:0] s;
        s = PDMA_STEP_WORD;
        if (size == PDMA_SIZE_BYTE) begin
            s = PDMA_STEP_BYTE;
        end else if (size == PDMA_SIZE_HALF) begin
            s = PDMA_STEP_HALF;
        end
        return s;
    endfunction

    // Storage slot that a view maps onto
    // Full duplex gives each view its own slot. Folding onto
    // slot 0 leaves the transmit slot idle on half duplex:
    // a few spare flops, but one code path for both modes.
    function automatic int slot(input int view);
        // Half duplex folds both views onto the receive slot
        return HALF_DUPLEX ? PDMA_RX : view;
    endfunction

    // A count still has elements to move
    function automatic logic len_live(input logic [15:0] len);
        return len != PDMA_LEN_RESET;
    endfunction

    // The element now moving is the last of its buffer
    function automatic logic len_last(input logic [15:0] len);
        return len == 16'h0001;
    endfunction

    // Decode helpers
    // acc marks the access phase; only there does a write
    // land, so setup cycles never disturb the registers.
    // The peripheral pulses are packed into per-view vectors.
    logic        acc;
    logic        wr;
    logic        mapped;
    logic [31:0] rd_word;
    logic [1:0]  done_in;
    logic [1:0]  ready_in;

    assign acc      = psel & penable;
    assign wr       = acc & pwrite;
    assign done_in  = {tx_xfer_done, rx_xfer_done};
    assign ready_in = {tx_ready, rx_ready};

    // Address decode for the access error; the read mux decodes on its own
    // Only exact word offsets are mapped; an unaligned or
    // out-of-range address is refused rather than aliased.
    always_comb begin
        unique case (paddr)
            PDMA_RX_BUFFER_POINTER, PDMA_RX_BUFFER_COUNT,
            PDMA_TX_BUFFER_POINTER, PDMA_TX_BUFFER_COUNT,
            PDMA_RX_FOLLOWING_POINTER, PDMA_RX_FOLLOWING_COUNT,
            PDMA_TX_FOLLOWING_POINTER, PDMA_TX_FOLLOWING_COUNT,
            PDMA_TRANSFER_CONTROL, PDMA_TRANSFER_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux; upper count bits and spare bits read zero
    // Views go through slot() so a half duplex peripheral
    // reads equal values from its receive and transmit views.
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            PDMA_RX_BUFFER_POINTER:    rd_word = st_q.cur_ptr[slot(PDMA_RX)];
            PDMA_TX_BUFFER_POINTER:    rd_word = st_q.cur_ptr[slot(PDMA_TX)];
            PDMA_RX_FOLLOWING_POINTER: rd_word = st_q.nxt_ptr[slot(PDMA_RX)];
            PDMA_TX_FOLLOWING_POINTER: rd_word = st_q.nxt_ptr[slot(PDMA_TX)];
            PDMA_RX_BUFFER_COUNT:    rd_word = {16'h0000, st_q.cur_len[slot(PDMA_RX)]};
            PDMA_TX_BUFFER_COUNT:    rd_word = {16'h0000, st_q.cur_len[slot(PDMA_TX)]};
            PDMA_RX_FOLLOWING_COUNT: rd_word = {16'h0000, st_q.nxt_len[slot(PDMA_RX)]};
            PDMA_TX_FOLLOWING_COUNT: rd_word = {16'h0000, st_q.nxt_len[slot(PDMA_TX)]};
            PDMA_TRANSFER_STATE: begin
                rd_word[PDMA_RX_REQUEST_ENABLE_BIT] = st_q.req_en[PDMA_RX];
                rd_word[PDMA_TX_REQUEST_ENABLE_BIT] = st_q.req_en[PDMA_TX];
            end
            default: rd_word = 32'h0000_0000; // Control is write-only
        endcase
    end

    // Next-state logic for every register
    always_comb begin
        logic       rxen;
        logic       rxdis;
        logic       txen;
        logic       txdis;
        logic [1:0] done_s;
        logic [1:0] clr;
        st_d   = st_q;
        rxen   = 1'b0;
        rxdis  = 1'b0;
        txen   = 1'b0;
        txdis  = 1'b0;
        done_s = 2'b00;
        clr    = 2'b00;

        // Read data captured in setup so it is ready in the access phase
        // Capturing early lets pready stay high with no wait state;
        // the cost is that a completion in the setup cycle itself
        // shows only on the next read.
        if (psel && !penable && !pwrite) begin
            st_d.prdata = rd_word;
        end

        // Element completions land on their storage slot
        // A pulse while disabled or with an empty count is
        // dropped, so a late pulse from the peripheral cannot
        // wrap a count below zero.
        for (int v = 0; v < 2; v++) begin
            if (done_in[v] && st_q.req_en[v] && len_live(st_q.cur_len[slot(v)])) begin
                done_s[slot(v)] = 1'b1;
            end
        end

        // The last element of a buffer moves the pointer and
        // then, if a following buffer waits, swaps it in at
        // once, so the channel goes on with no idle cycle.
        // With no following buffer the count rests at zero
        // and the request drops on the next cycle.
        // decrement, reload or stop
        for (int c = 0; c < 2; c++) begin
            if (done_s[c]) begin
                st_d.cur_ptr[c] = st_q.cur_ptr[c] + elem_step(elem_size);
                st_d.cur_len[c] = st_q.cur_len[c] - 16'h0001;
                if (len_last(st_q.cur_len[c])) begin
                    if (len_live(st_q.nxt_len[c])) begin
                        st_d.cur_ptr[c] = st_q.nxt_ptr[c];
                        st_d.cur_len[c] = st_q.nxt_len[c];
                        st_d.nxt_ptr[c] = PDMA_PTR_RESET;
                        st_d.nxt_len[c] = PDMA_LEN_RESET;
                    end
                end
            end
        end

        // Software writes win over a same-cycle completion on that register
        // Software that rewrites a running buffer expects its
        // value to stick; losing it to a completion would be
        // far harder to debug than losing one step.
        if (wr) begin
            unique case (paddr)
                // both views write one slot on half duplex
                PDMA_RX_BUFFER_POINTER:    st_d.cur_ptr[slot(PDMA_RX)] = pwdata;
                PDMA_TX_BUFFER_POINTER:    st_d.cur_ptr[slot(PDMA_TX)] = pwdata;
                PDMA_RX_FOLLOWING_POINTER: st_d.nxt_ptr[slot(PDMA_RX)] = pwdata;
                PDMA_TX_FOLLOWING_POINTER: st_d.nxt_ptr[slot(PDMA_TX)] = pwdata;
                PDMA_RX_FOLLOWING_COUNT: begin
                    st_d.nxt_len[slot(PDMA_RX)] = pwdata[PDMA_LEN_W-1:0];
                    clr[slot(PDMA_RX)] = |pwdata[PDMA_LEN_W-1:0];
                end
                PDMA_TX_FOLLOWING_COUNT: begin
                    st_d.nxt_len[slot(PDMA_TX)] = pwdata[PDMA_LEN_W-1:0];
                    clr[slot(PDMA_TX)] = |pwdata[PDMA_LEN_W-1:0];
                end
                PDMA_RX_BUFFER_COUNT: begin
                    st_d.cur_len[slot(PDMA_RX)] = pwdata[PDMA_LEN_W-1:0];
                    clr[slot(PDMA_RX)] = |pwdata[PDMA_LEN_W-1:0];
                end
                PDMA_TX_BUFFER_COUNT: begin
                    st_d.cur_len[slot(PDMA_TX)] = pwdata[PDMA_LEN_W-1:0];
                    clr[slot(PDMA_TX)] = |pwdata[PDMA_LEN_W-1:0];
                end
                PDMA_TRANSFER_CONTROL: begin
                    rxen  = pwdata[PDMA_RX_REQUEST_ENABLE_BIT];
                    rxdis = pwdata[PDMA_RX_REQUEST_DISABLE_BIT];
                    txen  = pwdata[PDMA_TX_REQUEST_ENABLE_BIT];
                    txdis = pwdata[PDMA_TX_REQUEST_DISABLE_BIT];
                end
                default: ;
            endcase
        end

        // Flags are cleared by a nonzero count write and set
        // by the last element; the set comes later in this
        // process so it wins when both fall in one cycle.
        // end flags; set beats a same-cycle clear
        for (int c = 0; c < 2; c++) begin
            if (clr[c]) begin
                st_d.end_flag[c] = 1'b0;
                st_d.all_done[c] = 1'b0;
            end
            if (done_s[c] && len_last(st_q.cur_len[c])) begin
                st_d.end_flag[c] = 1'b1;
                if (st_q.nxt_len[c] == PDMA_LEN_RESET) begin
                    st_d.all_done[c] = 1'b1;
                end
            end
        end

        // Enables are applied first and disables last, so a
        // disable always wins over an enable in one write.
        // On half duplex receive wins over transmit when both
        // enables are written; software must not do so, and
        // the result is at least never both channels running.
        // receive enable, blocked by its own disable
        if (rxen && !rxdis) begin
            st_d.req_en[PDMA_RX] = 1'b1;
            if (HALF_DUPLEX) begin
                st_d.req_en[PDMA_TX] = 1'b0;
            end
        end
        // ignored on half duplex while receive enable is written
        if (txen && !txdis && !(HALF_DUPLEX && rxen)) begin
            st_d.req_en[PDMA_TX] = 1'b1;
        end
        if (rxdis) begin
            st_d.req_en[PDMA_RX] = 1'b0;
            if (HALF_DUPLEX) begin
                st_d.req_en[PDMA_TX] = 1'b0;
            end
        end
        if (txdis) begin
            st_d.req_en[PDMA_TX] = 1'b0;
            if (HALF_DUPLEX) begin
                st_d.req_en[PDMA_RX] = 1'b0;
            end
        end
    end

    // The reset branch loads constants only, so release
    // timing cannot leak data into the registers.
    // state register, all zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // APB answers in the first access cycle
    // pslverr is combinational from the address and only
    // stands while the access phase does.
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = st_q.prdata;

    // Requests are combinational from flops and ready, so the
    // peripheral sees a stall as soon as it drops ready.
    // receive requests run only with a nonzero count
    assign rx_xfer_req = st_q.req_en[PDMA_RX] & rx_ready
                       & len_live(st_q.cur_len[slot(PDMA_RX)]);
    // transmit requests run only with a nonzero count
    assign tx_xfer_req = st_q.req_en[PDMA_TX] & tx_ready
                       & len_live(st_q.cur_len[slot(PDMA_TX)]);

    // Memory addresses straight from the pointer flops
    // A pointer rewritten mid-buffer is used from the next element.
    assign rx_mem_addr = st_q.cur_ptr[slot(PDMA_RX)];
    assign tx_mem_addr = st_q.cur_ptr[slot(PDMA_TX)];

    // Flags from flops; half duplex shows the shared slot on both views
    // The host peripheral decides what to do with them.
    assign flags.rx_end_flag      = st_q.end_flag[slot(PDMA_RX)];
    assign flags.rx_all_done_flag = st_q.all_done[slot(PDMA_RX)];
    assign flags.tx_end_flag      = st_q.end_flag[slot(PDMA_TX)];
    assign flags.tx_all_done_flag = st_q.all_done[slot(PDMA_TX)];


    // Limits: no bus arbitration or data path here; the
    // peripheral's done pulses stand for the moved elements.
    // Counts are 16 bits, so one buffer holds at most 65535
    // elements; longer moves must chain following buffers.

endmodule // pdma_channel_regs

// ---- pdma_channel_regs_properties.sv ----
`timescale 1ns/1ns
module pdma_channel_regs_properties
    import pdma_pkg::*;
#(
    parameter bit HALF_DUPLEX = 1'b0
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Peripheral side
    input wire logic [1:0]  elem_size,
    input wire logic        rx_ready,
    input wire logic        tx_ready,
    input wire logic        rx_xfer_done,
    input wire logic        tx_xfer_done,
    input wire logic        rx_xfer_req,
    input wire logic        tx_xfer_req,
    input wire logic [31:0] rx_mem_addr,
    input wire logic [31:0] tx_mem_addr,
    input wire pdma_flags_s flags
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] step_w;
    // Pointer step per element size; sizes 2 and 3 both mean a word
    assign step_w = (elem_size == PDMA_SIZE_BYTE) ? PDMA_STEP_BYTE :
                    (elem_size == PDMA_SIZE_HALF) ? PDMA_STEP_HALF : PDMA_STEP_WORD;

    a_unmapped_error: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_clean: assert property (psel && penable && paddr <= 12'h024 && paddr[1:0] == 2'h0
        |-> pready && !pslverr) else $error("mapped access stalled or refused");
    a_rx_req_gate: assert property (rx_xfer_req |-> rx_ready)
        else $error("receive request without ready");
    a_tx_req_gate: assert property (tx_xfer_req |-> tx_ready)
        else $error("transmit request without ready");
    a_rx_ptr_step: assert property (!HALF_DUPLEX && rx_xfer_req && rx_xfer_done && !psel
        |=> rx_mem_addr == $past(rx_mem_addr) + $past(step_w) || flags.rx_end_flag)
        else $error("receive pointer step wrong");
    a_tx_ptr_step: assert property (!HALF_DUPLEX && tx_xfer_req && tx_xfer_done && !psel
        |=> tx_mem_addr == $past(tx_mem_addr) + $past(step_w) || flags.tx_end_flag)
        else $error("transmit pointer step wrong");
    a_rx_idle_hold: assert property (!HALF_DUPLEX && rx_ready && !rx_xfer_req && !psel
        |=> $stable(rx_mem_addr)) else $error("idle receive pointer moved");
    a_rx_flag_sticky: assert property (flags.rx_all_done_flag && !(psel && pwrite)
        |=> flags.rx_all_done_flag) else $error("receive done flag lost");
    a_tx_flag_sticky: assert property (flags.tx_all_done_flag && !(psel && pwrite)
        |=> flags.tx_all_done_flag) else $error("transmit done flag lost");
endmodule // pdma_channel_regs_properties

bind pdma_channel_regs pdma_channel_regs_properties #(.HALF_DUPLEX(HALF_DUPLEX)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .elem_size(elem_size), .rx_ready(rx_ready), .tx_ready(tx_ready),
    .rx_xfer_done(rx_xfer_done), .tx_xfer_done(tx_xfer_done), .rx_xfer_req(rx_xfer_req),
    .tx_xfer_req(tx_xfer_req), .rx_mem_addr(rx_mem_addr), .tx_mem_addr(tx_mem_addr),
    .flags(flags));

// ---- pdma_periph_model.sv ----
`timescale 1ns/1ns
module pdma_periph_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench control
    input  wire logic [1:0] ready_en,
    input  wire logic       slow,
    // Channel side
    input  wire logic       rx_xfer_req,
    input  wire logic       tx_xfer_req,
    output logic            rx_ready,
    output logic            tx_ready,
    output logic            rx_xfer_done,
    output logic            tx_xfer_done
);
    logic [7:0] lfsr_q;
    // Slow mode drops ready at irregular cycles so stalls land mid-buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q       <= 8'hA5;
            rx_ready     <= 1'b0;
            tx_ready     <= 1'b0;
            rx_xfer_done <= 1'b0;
            tx_xfer_done <= 1'b0;
        end else begin
            lfsr_q       <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            rx_ready     <= ready_en[0] & (!slow | lfsr_q[0]);
            tx_ready     <= ready_en[1] & (!slow | lfsr_q[1]);
            // One pulse per grant; a gap lets the count move before the next
            rx_xfer_done <= rx_xfer_req & !rx_xfer_done;
            tx_xfer_done <= tx_xfer_req & !tx_xfer_done;
        end
    end
endmodule // pdma_periph_model

// ---- pdma_channel_regs_bench.sv ----
`timescale 1ns/1ns
module pdma_channel_regs_bench;
    import pdma_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
    logic        rx_ready, tx_ready, rx_xfer_done, tx_xfer_done, rx_xfer_req, tx_xfer_req;
    logic [11:0] paddr, b;
    logic [31:0] pwdata, prdata, rx_mem_addr, tx_mem_addr, q, w, p1;
    logic [1:0]  elem_size, ready_en;
    pdma_flags_s flags;
    int          num_errors, samples_checked, n;
    logic [31:0] seed = 32'h0000_003F;
    logic [31:0] ctl_w [7] = '{32'h1, 32'h100, 32'h2, 32'h3, 32'h0, 32'h200, 32'hFFFF_FCFC};
    logic [31:0] ctl_s [7] = '{32'h1, 32'h101, 32'h100, 32'h100, 32'h100, 32'h0, 32'h0};

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    pdma_channel_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .elem_size(elem_size), .rx_ready(rx_ready), .tx_ready(tx_ready),
        .rx_xfer_done(rx_xfer_done), .tx_xfer_done(tx_xfer_done), .rx_xfer_req(rx_xfer_req),
        .tx_xfer_req(tx_xfer_req), .rx_mem_addr(rx_mem_addr), .tx_mem_addr(tx_mem_addr),
        .flags(flags));
    pdma_periph_model u_periph (.pclk(pclk), .presetn(presetn), .ready_en(ready_en),
        .slow(slow), .rx_xfer_req(rx_xfer_req), .tx_xfer_req(tx_xfer_req),
        .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_xfer_done(rx_xfer_done),
        .tx_xfer_done(tx_xfer_done));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] step_of(input logic [1:0] sz);
        return (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Setup then access; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            $display("unexpected at %0t: bus answer missing", $time);
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        {presetn, psel, penable, pwrite, slow} = '0;
        paddr = '0;
        pwdata = '0;
        elem_size = '0;
        ready_en = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Every register reads zero after reset; the place past the map is refused
        for (int i = 0; i <= 10; i++) begin
            apb(1'b0, 12'(4 * i), '0);
            check(q, '0, "reset value");
            check({31'h0, e}, {31'h0, i == 10}, "error flag");
        end
        $display("test reset_map done");
        // Random readback; counter tops and read-only state stay zero
        for (int i = 0; i < 8; i++) begin
            w = rnd();
            apb(1'b1, 12'(4 * i), w);
            apb(1'b0, 12'(4 * i), '0);
            check(q, i[0] ? {16'h0, w[15:0]} : w, "readback");
        end
        apb(1'b1, PDMA_TRANSFER_STATE, 32'hFFFF_FFFF);
        apb(1'b0, PDMA_TRANSFER_STATE, '0);
        check(q, '0, "state after write");
        $display("test readback done");
        // Enable and disable sequence, including both at once and stray bits
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, PDMA_TRANSFER_CONTROL, ctl_w[i]);
            apb(1'b0, PDMA_TRANSFER_STATE, '0);
            check(q, ctl_s[i], "enable state");
        end
        $display("test control done");
        // Two chained buffers per channel, prompt then stalling peripheral
        for (int ch = 0; ch < 2; ch++) begin
            b = 12'(8 * ch);
            w = rnd();
            p1 = rnd();
            elem_size <= w[1:0];
            slow <= ch[0];
            ready_en <= 2'b11;
            apb(1'b1, b, rnd());
            apb(1'b1, b + 12'h004, 32'h3);
            apb(1'b1, b + 12'h010, p1);
            apb(1'b1, b + 12'h014, 32'h2);
            apb(1'b1, PDMA_TRANSFER_CONTROL, ch ? 32'h100 : 32'h1);
            for (n = 0; n < 400 && (ch ? flags.tx_all_done_flag : flags.rx_all_done_flag) !== 1'b1;
                 n++)
                @(posedge pclk);
            if (n >= 400) begin
                num_errors++;
                $display("unexpected at %0t: buffers never finished", $time);
                tally_and_finish();
            end
            check(ch ? tx_mem_addr : rx_mem_addr, p1 + 2 * step_of(w[1:0]), "end address");
            check({31'h0, ch ? tx_xfer_req : rx_xfer_req}, '0, "request after end");
            check({31'h0, ch ? flags.tx_end_flag : flags.rx_end_flag}, 32'h1, "end flag");
            for (int r = 1; r < 4; r++) begin
                apb(1'b0, b + 12'(r == 1 ? 4 : 8 + 4 * r), '0);
                check(q, '0, "count or next after end");
            end
            apb(1'b1, PDMA_TRANSFER_CONTROL, 32'h202);
            $display("test chain %0d done", ch);
        end
        tally_and_finish();
    end
endmodule // pdma_channel_regs_bench
